// ### pkg/clkmgr_pkg.sv
`default_nettype none
package clkmgr_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] SHIFT_OFS = 5'h04;
   localparam logic [4:0] STATUS_OFS = 5'h08;
   localparam logic [4:0] NET_OFS = 5'h0c;
   localparam logic [4:0] MEASURE_OFS = 5'h10;

   // Control register fields.
   localparam int CTRL_MGR_RESET_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_HIGH_FREQ_BIT = 3;
   localparam int CTRL_MULT_LSB = 8;
   localparam int CTRL_DIV_LSB = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0001_0200;
   localparam logic [31:0] CTRL_WRITE_MASK = 32'h00ff_ff0e;

   // Shift value field and its limits.
   localparam int SHIFT_WIDTH = 9;
   localparam logic signed [9:0] SHIFT_MAX = 10'sh0ff;
   localparam logic signed [9:0] SHIFT_MIN = -10'sh0ff;
   localparam int FRACTION_BITS = 8;

   // Status byte fields.
   localparam int ST_LOCKED = 0;
   localparam int ST_AT_LIMIT = 1;
   localparam int ST_REF_STOPPED = 2;
   localparam int ST_FB_STOPPED = 3;
   localparam int ST_SHIFT_ACTIVE = 4;
   localparam int ST_SHIFT_UNAVAILABLE = 5;

   // Consecutive matching phase compares before lock is reported.
   localparam logic [3:0] LOCK_COUNT = 4'h8;
   // Shortest measurable reference period, in clock cycles.
   localparam int MIN_PERIOD = 4;

   typedef enum logic [1:0] {
      SHIFT_NONE = 2'b00,
      SHIFT_FIXED = 2'b01,
      SHIFT_VARIABLE = 2'b10
   } shift_mode_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avalon_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avalon_rsp_t;

   typedef struct packed {
      logic zero_degree;
      logic quarter;
      logic half;
      logic three_quarter;
   } out_clocks_t;

endpackage : clkmgr_pkg
`default_nettype wire

// ### core/tap_delay_line.sv
`default_nettype none
module tap_delay_line #(
   parameter int DEPTH = 256,
   parameter int TAPS = 4,
   localparam int P = $clog2(DEPTH)
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic sample_in,
   input wire logic [TAPS-1:0][P-1:0] delays,
   output logic [TAPS-1:0] taps_out
);

   typedef struct packed {
      logic [DEPTH-1:0] hist;
      logic [P-1:0] wr_ptr;
   } line_state_t;

   line_state_t s_r;
   line_state_t s_nxt;

   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tap_delay_line: DEPTH must be a power of two of at least 16");
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.hist[s_r.wr_ptr] = sample_in;
      s_nxt.wr_ptr = s_r.wr_ptr + P'(1);
   end

   // Delay zero returns the most recently stored sample.
   always_comb begin
      for (int i = 0; i < TAPS; i++) begin
         taps_out[i] = s_r.hist[P'(s_r.wr_ptr - P'(1) - delays[i])];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule : tap_delay_line
`default_nettype wire

// ### core/clock_manager.sv
// Notes on behaviour
// - Shifter works only in low-frequency loop mode.
// - Step is larger of period/256 or tap.
// - Same fine offset moves all outputs together.
// - Coarse output phases add the fine offset.
// - Mode selects none, fixed or variable shifting.
// - Disabled shifter keeps zero phase; inputs held low.
// - Offset equals shift times max(period, tap) over 256.
// - Positive delays feedback, negative advances it.
// - Zero shift aligns feedback like disabled shifter.
// - Net steps are increments minus decrements, bounded.
// - Positive net increments phase, negative decrements.
// - Manager reset keeps all configured settings.
// - Eight-bit status bus plus manager reset means.
// - Tap chain loop aligns feedback to reference.
`default_nettype none
module clock_manager #(
   parameter int DEPTH = 256,
   parameter int TAP_Q8 = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire clkmgr_pkg::avalon_req_t bus_req,
   output clkmgr_pkg::avalon_rsp_t bus_rsp,
   input wire logic reference_clock_in,
   input wire logic feedback_clock_in,
   input wire logic shift_control_clock,
   input wire logic shift_step_enable,
   input wire logic shift_direction,
   output clkmgr_pkg::out_clocks_t clocks_out,
   output logic [7:0] status_out
);

   localparam int P = $clog2(DEPTH);
   localparam logic [P:0] HALF_DEPTH = (P + 1)'(DEPTH / 2);
   localparam logic [P:0] ONE_W = (P + 1)'(1);
   localparam logic [P:0] MIN_P = (P + 1)'(clkmgr_pkg::MIN_PERIOD);
   localparam logic [P-1:0] TAP_UNIT = P'(TAP_Q8);

   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 65536) begin : g_bad_depth
      $error("clock_manager: DEPTH must be a power of two from 16 to 65536");
   end
   if (TAP_Q8 < 1 || TAP_Q8 >= DEPTH / 2) begin : g_bad_tap
      $error("clock_manager: TAP_Q8 must lie between 1 and DEPTH/2 - 1");
   end

   typedef struct packed {
      logic ref_q;
      logic fb_q;
      logic shift_control_clock_q;
      logic [P:0] since_ref;
      logic [P:0] since_fb;
      logic [P-1:0] period;
      logic period_ok;
      logic [P-1:0] tap;
      logic [3:0] lock_cnt;
      logic locked;
      logic signed [9:0] net;
      logic [31:0] ctrl;
      logic signed [8:0] shift_cfg;
      logic mgr_reset;
      logic [31:0] readdata;
      logic waitrequest;
      clkmgr_pkg::out_clocks_t clocks;
      logic [7:0] status;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   function automatic logic signed [9:0] clamp_shift(input logic signed [9:0] v);
      if (v > clkmgr_pkg::SHIFT_MAX) begin
         return clkmgr_pkg::SHIFT_MAX;
      end else if (v < clkmgr_pkg::SHIFT_MIN) begin
         return clkmgr_pkg::SHIFT_MIN;
      end
      return v;
   endfunction : clamp_shift

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   function automatic logic [P-1:0] wrap_add(input logic [P-1:0] a, input logic [P-1:0] b,
                                            input logic [P-1:0] period);
      logic [P:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      if (sum >= {1'b0, period}) begin
         sum = sum - {1'b0, period};
      end
      return sum[P-1:0];
   endfunction : wrap_add

   logic ref_rise;
   logic fb_rise;
   logic ps_rise;
   clkmgr_pkg::shift_mode_t mode;
   logic high_freq;
   logic shifter_on;
   logic shifter_wanted;
   logic signed [9:0] eff_shift;
   logic [7:0] mag;
   logic [P-1:0] step_q8;
   logic [P+7:0] product;
   logic [P-1:0] offset;
   logic [P-1:0] target;
   logic [P-1:0] quarter;
   logic [3:0][P-1:0] delays;
   logic [3:0] taps;
   logic signed [P+1:0] err;
   logic at_limit;
   logic fb_stopped;

   assign ref_rise = reference_clock_in & ~s_r.ref_q;
   assign fb_rise = feedback_clock_in & ~s_r.fb_q;
   assign ps_rise = shift_control_clock & ~s_r.shift_control_clock_q;
   assign high_freq = s_r.ctrl[clkmgr_pkg::CTRL_HIGH_FREQ_BIT];
   assign fb_stopped = s_r.since_fb >= HALF_DEPTH;
   assign at_limit = (s_r.net == clkmgr_pkg::SHIFT_MAX) || (s_r.net == clkmgr_pkg::SHIFT_MIN);

   always_comb begin
      unique case (s_r.ctrl[clkmgr_pkg::CTRL_MODE_LSB +: 2])
         2'b01: mode = clkmgr_pkg::SHIFT_FIXED;
         2'b10: mode = clkmgr_pkg::SHIFT_VARIABLE;
         default: mode = clkmgr_pkg::SHIFT_NONE;
      endcase
   end

   assign shifter_wanted = mode != clkmgr_pkg::SHIFT_NONE;
   assign shifter_on = shifter_wanted & ~high_freq;

   // Variable mode starts from the configured value and adds the net step count.
   always_comb begin
      if (!shifter_on) begin
         eff_shift = '0;
      end else if (mode == clkmgr_pkg::SHIFT_VARIABLE) begin
         eff_shift = clamp_shift(10'(s_r.shift_cfg) + s_r.net);
      end else begin
         eff_shift = 10'(s_r.shift_cfg);
      end
   end

   // Offset in cycles is magnitude times max(period/256, tap), in 1/256 cycle units.
   assign mag = eff_shift[9] ? 8'(-eff_shift) : eff_shift[7:0];
   assign step_q8 = (s_r.period > TAP_UNIT) ? s_r.period : TAP_UNIT;
   assign product = (P + 8)'(mag) * (P + 8)'(step_q8);
   always_comb begin
      offset = product[P+7:clkmgr_pkg::FRACTION_BITS];
      if (offset >= s_r.period) begin
         offset = P'(offset - s_r.period);
      end
   end

   // Positive lags the feedback edge, negative lands it before the reference edge.
   always_comb begin
      if (eff_shift[9] && offset != '0) begin
         target = P'(s_r.period - offset);
      end else begin
         target = offset;
      end
   end

   // All outputs hang off one loop tap, so the fine offset moves them together.
   assign quarter = P'(s_r.period >> 2);
   assign delays[0] = s_r.tap;
   assign delays[1] = P'(s_r.tap + quarter);
   assign delays[2] = P'(s_r.tap + P'(s_r.period >> 1));
   assign delays[3] = P'(s_r.tap + P'(s_r.period >> 1) + quarter);

   tap_delay_line #(
      .DEPTH(DEPTH),
      .TAPS(4)
   ) u_line (
      .clock(clock),
      .srst(srst),
      .sample_in(reference_clock_in),
      .delays(delays),
      .taps_out(taps)
   );

   // Signed distance from the measured feedback lag to the target, wrapped to half a period.
   always_comb begin
      err = $signed({2'b00, target}) - $signed({1'b0, s_r.since_ref});
      if (err > $signed({2'b00, s_r.period >> 1})) begin
         err = err - $signed({2'b00, s_r.period});
      end else if (err < -$signed({2'b00, s_r.period >> 1})) begin
         err = err + $signed({2'b00, s_r.period});
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.ref_q = reference_clock_in;
      s_nxt.fb_q = feedback_clock_in;
      s_nxt.shift_control_clock_q = shift_control_clock;
      s_nxt.mgr_reset = 1'b0;

      // Reference period measurement; a stalled reference drops lock.
      if (ref_rise) begin
         s_nxt.since_ref = '0;
         s_nxt.period_ok = (s_r.since_ref < HALF_DEPTH) && (s_r.since_ref + ONE_W >= MIN_P);
         s_nxt.period = P'(s_r.since_ref + ONE_W);
         s_nxt.locked = s_r.locked & s_nxt.period_ok;
      end else if (s_r.since_ref != '1) begin
         s_nxt.since_ref = s_r.since_ref + ONE_W;
      end
      if (s_r.since_ref >= HALF_DEPTH) begin
         s_nxt.period_ok = 1'b0;
         s_nxt.locked = 1'b0;
         s_nxt.lock_cnt = '0;
      end
      if (fb_rise) begin
         s_nxt.since_fb = '0;
      end else if (s_r.since_fb != '1) begin
         s_nxt.since_fb = s_r.since_fb + ONE_W;
      end

      // Phase detector moves the loop tap one step per feedback edge.
      if (fb_rise && s_r.period_ok && s_nxt.period_ok) begin
         if (err > 0) begin
            s_nxt.tap = wrap_add(s_r.tap, P'(1), s_r.period);
         end else if (err < 0) begin
            s_nxt.tap = wrap_add(s_r.tap, P'(s_r.period - P'(1)), s_r.period);
         end
         if (err == 0) begin
            if (s_r.lock_cnt != clkmgr_pkg::LOCK_COUNT) begin
               s_nxt.lock_cnt = s_r.lock_cnt + 4'h1;
            end else begin
               s_nxt.locked = 1'b1;
            end
         end else begin
            s_nxt.lock_cnt = '0;
            if (err > 1 || err < -1) begin
               s_nxt.locked = 1'b0;
            end
         end
      end

      // Run-time stepping; fixed and disabled modes ignore the step inputs.
      if (shifter_on && mode == clkmgr_pkg::SHIFT_VARIABLE && ps_rise && shift_step_enable) begin
         if (shift_direction) begin
            s_nxt.net = clamp_shift(s_r.net + 10'sh001);
         end else begin
            s_nxt.net = clamp_shift(s_r.net - 10'sh001);
         end
      end

      // Manager reset clears loop and stepping state, never the configuration.
      if (s_r.mgr_reset) begin
         s_nxt.since_ref = '0;
         s_nxt.since_fb = '0;
         s_nxt.period = '0;
         s_nxt.period_ok = 1'b0;
         s_nxt.tap = '0;
         s_nxt.lock_cnt = '0;
         s_nxt.locked = 1'b0;
         s_nxt.net = '0;
      end

      // Slave answers one cycle after the request; the write lands on the edge after waitrequest drops.
      if (!s_r.waitrequest) begin
         s_nxt.waitrequest = 1'b1;
         if (bus_req.write) begin
            unique case (bus_req.address)
               clkmgr_pkg::CTRL_OFS: begin
                  s_nxt.ctrl = merge_bytes(s_r.ctrl, bus_req.writedata, bus_req.byteenable)
                               & clkmgr_pkg::CTRL_WRITE_MASK;
                  s_nxt.mgr_reset = bus_req.byteenable[0]
                                    & bus_req.writedata[clkmgr_pkg::CTRL_MGR_RESET_BIT];
               end
               clkmgr_pkg::SHIFT_OFS: begin
                  s_nxt.shift_cfg = 9'(merge_bytes(32'(s_r.shift_cfg), bus_req.writedata,
                                                   bus_req.byteenable));
               end
               default: begin
               end
            endcase
         end
      end else if (bus_req.read || bus_req.write) begin
         s_nxt.waitrequest = 1'b0;
         s_nxt.readdata = '0;
         if (bus_req.read) begin
            unique case (bus_req.address)
               clkmgr_pkg::CTRL_OFS: s_nxt.readdata = s_r.ctrl;
               clkmgr_pkg::SHIFT_OFS: s_nxt.readdata = 32'($signed(s_r.shift_cfg));
               clkmgr_pkg::STATUS_OFS: s_nxt.readdata = 32'(s_r.status);
               clkmgr_pkg::NET_OFS: s_nxt.readdata = 32'($signed(s_r.net));
               clkmgr_pkg::MEASURE_OFS: s_nxt.readdata = {16'(offset), 16'(s_r.period)};
               default: s_nxt.readdata = '0;
            endcase
         end
      end

      s_nxt.clocks.zero_degree = taps[0];
      s_nxt.clocks.quarter = taps[1];
      s_nxt.clocks.half = taps[2];
      s_nxt.clocks.three_quarter = taps[3];

      s_nxt.status = '0;
      s_nxt.status[clkmgr_pkg::ST_LOCKED] = s_r.locked;
      s_nxt.status[clkmgr_pkg::ST_AT_LIMIT] = at_limit;
      s_nxt.status[clkmgr_pkg::ST_REF_STOPPED] = ~s_r.period_ok;
      s_nxt.status[clkmgr_pkg::ST_FB_STOPPED] = fb_stopped;
      s_nxt.status[clkmgr_pkg::ST_SHIFT_ACTIVE] = shifter_on;
      s_nxt.status[clkmgr_pkg::ST_SHIFT_UNAVAILABLE] = shifter_wanted & high_freq;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= '0;
         s_r.ctrl <= clkmgr_pkg::CTRL_RESET;
         s_r.waitrequest <= 1'b1;
         s_r.status <= 8'h04;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus_rsp.readdata = s_r.readdata;
   assign bus_rsp.waitrequest = s_r.waitrequest;
   assign clocks_out = s_r.clocks;
   assign status_out = s_r.status;

endmodule : clock_manager
`default_nettype wire

// ### tb/clock_manager_chk.sv
`default_nettype none
module clock_manager_chk #(
   parameter int DEPTH = 256,
   parameter int TAP_Q8 = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire clkmgr_pkg::avalon_req_t bus_req,
   input wire clkmgr_pkg::avalon_rsp_t bus_rsp,
   input wire logic shift_step_enable,
   input wire clkmgr_pkg::out_clocks_t clocks_out,
   input wire logic [7:0] status_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic taken;
   logic rd_taken;
   logic [3:0] en_age_r;
   logic [3:0] en_age_nxt;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   assign taken = (bus_req.read | bus_req.write) & bus_rsp.waitrequest;
   assign rd_taken = taken & bus_req.read;
   // Cycles since the step enable was last high, saturating.
   always_comb begin
      en_age_nxt = (en_age_r == 4'hf) ? en_age_r : en_age_r + 4'h1;
      if (srst || shift_step_enable) begin
         en_age_nxt = 4'h0;
      end
   end
   always_ff @(posedge clock) begin
      en_age_r <= en_age_nxt;
   end
   a_wait_answer: assert property (taken |=> !bus_rsp.waitrequest)
      else $error("waitrequest did not drop one cycle after a request");
   a_wait_single: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
      else $error("waitrequest stayed low for more than one cycle");
   a_wait_cause: assert property (!bus_rsp.waitrequest |-> $past(bus_req.read | bus_req.write))
      else $error("waitrequest dropped without a request");
   a_reset_state: assert property (disable iff (1'b0) srst |=>
      status_out == 8'h04 && clocks_out == '0 && bus_rsp.waitrequest)
      else $error("outputs not at their reset values after srst");
   a_unmapped_zero: assert property (rd_taken && (bus_req.address > clkmgr_pkg::MEASURE_OFS
      || bus_req.address[1:0] != 2'h0) |=> bus_rsp.readdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   a_ctrl_fields: assert property (rd_taken && bus_req.address == clkmgr_pkg::CTRL_OFS |=>
      (bus_rsp.readdata & ~clkmgr_pkg::CTRL_WRITE_MASK) == 32'h0)
      else $error("control read shows bits outside its fields");
   a_hf_blocks: assert property (status_out[5] |-> !status_out[4])
      else $error("shifter active in high-frequency mode");
   a_top_zero: assert property (status_out[7:6] == 2'h0)
      else $error("unused status bits set");
   a_limit_step: assert property ($rose(status_out[1]) |-> en_age_r < 4'h6)
      else $error("limit flag rose without a recent step");
   a_phase_shared: assert property (status_out[0] |->
      clocks_out.half != clocks_out.zero_degree && clocks_out.three_quarter != clocks_out.quarter)
      else $error("coarse phases not moved together");
   a_lock_ref: assert property (status_out[0] |-> !status_out[2])
      else $error("locked while the reference is unmeasured");
   c_locked: cover property (status_out[0]);
   c_limit: cover property ($rose(status_out[1]));
   c_unavail: cover property (status_out[5]);
endmodule : clock_manager_chk
bind clock_manager clock_manager_chk #(.DEPTH(DEPTH), .TAP_Q8(TAP_Q8)) i_clock_manager_chk (
   .clock(clock), .srst(srst), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .shift_step_enable(shift_step_enable), .clocks_out(clocks_out), .status_out(status_out)
);
`default_nettype wire

// ### tb/fabric_partner.sv
`default_nettype none
module fabric_partner #(
   parameter int HALF = 16
) (
   input wire logic clock,
   input wire logic zero_degree,
   output logic reference_clock_in,
   output logic feedback_clock_in,
   output logic shift_control_clock,
   output logic shift_step_enable,
   output logic shift_direction
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   assign feedback_clock_in = zero_degree;
   initial begin
      cnt = 0;
      reference_clock_in = 1'b0;
      shift_control_clock = 1'b0;
      shift_step_enable = 1'b0;
      shift_direction = 1'b0;
      forever begin
         @(posedge clock);
         cnt = (cnt + 1) % HALF;
         if (cnt == 0) begin
            reference_clock_in <= ~reference_clock_in;
         end
      end
   end
   // One step per shift-clock period; slow stretches the low phase.
   task automatic step(input logic up, input int n, input int slow);
      for (int i = 0; i < n; i++) begin
         shift_control_clock <= 1'b1;
         shift_step_enable <= 1'b1;
         shift_direction <= up;
         repeat (2) @(posedge clock);
         shift_control_clock <= 1'b0;
         shift_step_enable <= 1'b0;
         shift_direction <= 1'b0;
         repeat (2 + slow) @(posedge clock);
      end
   endtask : step
endmodule : fabric_partner
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic w;
      logic [4:0] a;
      logic [31:0] d;
   } row_t;
   row_t rows [11];
   logic clock;
   logic srst;
   clkmgr_pkg::avalon_req_t req;
   clkmgr_pkg::avalon_rsp_t rsp;
   clkmgr_pkg::out_clocks_t clks;
   logic [7:0] status;
   logic ref_clk, fb_clk, sclk, sen, sdir;
   logic [31:0] q;
   int fails, checks_done, l0, lp, ln;
   clock_manager i_clock_manager (
      .clock(clock), .srst(srst), .bus_req(req), .bus_rsp(rsp),
      .reference_clock_in(ref_clk), .feedback_clock_in(fb_clk),
      .shift_control_clock(sclk), .shift_step_enable(sen), .shift_direction(sdir),
      .clocks_out(clks), .status_out(status)
   );
   fabric_partner i_fabric_partner (
      .clock(clock), .zero_degree(clks.zero_degree), .reference_clock_in(ref_clk),
      .feedback_clock_in(fb_clk), .shift_control_clock(sclk), .shift_step_enable(sen),
      .shift_direction(sdir)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
         output logic [31:0] rdata);
      req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
      do begin
         @(posedge clock);
      end while (rsp.waitrequest !== 1'b0);
      rdata = rsp.readdata;
      req <= '0;
      @(posedge clock);
   endtask : xfer
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask : rd
   task automatic wait_chk(input int b, input logic v);
      int n;
      n = 0;
      while (status[b] !== v && n < 6000) begin
         @(posedge clock);
         n++;
      end
      chk(status[b], v);
   endtask : wait_chk
   // Cycles from a reference rise to the next zero-degree rise.
   task automatic lag(output int l);
      time t0;
      @(posedge ref_clk);
      t0 = $time;
      @(posedge clks.zero_degree);
      l = int'(($time - t0) / 8);
      @(posedge clock);
   endtask : lag
   task automatic end_of_test();
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      end_of_test();
   end
   initial begin
      srst = 1'b1;
      req = '0;
      fails = 0;
      checks_done = 0;
      rows = '{'{1'b0, 5'h00, 32'h0001_0200}, '{1'b1, 5'h00, 32'hffff_ffff},
         '{1'b0, 5'h00, 32'h00ff_ff0e}, '{1'b1, 5'h00, 32'h0001_0200},
         '{1'b1, 5'h04, 32'h0000_01ff}, '{1'b0, 5'h04, 32'hffff_ffff},
         '{1'b1, 5'h14, 32'hffff_ffff}, '{1'b0, 5'h14, 32'h0000_0000},
         '{1'b1, 5'h0c, 32'h1234_5678}, '{1'b0, 5'h0c, 32'h0000_0000},
         '{1'b1, 5'h04, 32'h0000_0000}};
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      chk(status, 8'h04);
      @(posedge clock);
      foreach (rows[i]) begin
         xfer(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) chk(q, rows[i].d);
      end
      wait_chk(0, 1'b1);
      lag(l0);
      rd(clkmgr_pkg::MEASURE_OFS, 32'h0000_0020);
      rd(clkmgr_pkg::STATUS_OFS, 32'h0000_0001);
      xfer(1'b1, clkmgr_pkg::SHIFT_OFS, 32'h0000_0040, q);
      xfer(1'b1, clkmgr_pkg::CTRL_OFS, 32'h0001_0202, q);
      repeat (100) @(posedge clock);
      wait_chk(0, 1'b1);
      lag(lp);
      rd(clkmgr_pkg::MEASURE_OFS, 32'h0008_0020);
      chk(status[4], 1'b1);
      i_fabric_partner.step(1'b1, 3, 0);
      rd(clkmgr_pkg::NET_OFS, 32'h0);
      xfer(1'b1, clkmgr_pkg::SHIFT_OFS, 32'hffff_ffc0, q);
      repeat (100) @(posedge clock);
      wait_chk(0, 1'b1);
      lag(ln);
      rd(clkmgr_pkg::MEASURE_OFS, 32'h0008_0020);
      chk((lp - l0) & 31, 32'h8);
      chk((ln - l0) & 31, 32'h18);
      xfer(1'b1, clkmgr_pkg::SHIFT_OFS, 32'h0, q);
      xfer(1'b1, clkmgr_pkg::CTRL_OFS, 32'h0001_0204, q);
      i_fabric_partner.step(1'b1, 3, 0);
      rd(clkmgr_pkg::NET_OFS, 32'h0000_0003);
      i_fabric_partner.step(1'b0, 5, 3);
      rd(clkmgr_pkg::NET_OFS, 32'hffff_fffe);
      i_fabric_partner.step(1'b1, 300, 0);
      rd(clkmgr_pkg::NET_OFS, 32'h0000_00ff);
      chk(status[1], 1'b1);
      rd(clkmgr_pkg::MEASURE_OFS, 32'h001f_0020);
      xfer(1'b1, clkmgr_pkg::CTRL_OFS, 32'h0001_0205, q);
      rd(clkmgr_pkg::NET_OFS, 32'h0);
      rd(clkmgr_pkg::CTRL_OFS, 32'h0001_0204);
      chk(status[1], 1'b0);
      xfer(1'b1, clkmgr_pkg::CTRL_OFS, 32'h0001_020c, q);
      wait_chk(5, 1'b1);
      chk(status[4], 1'b0);
      i_fabric_partner.step(1'b1, 2, 0);
      rd(clkmgr_pkg::NET_OFS, 32'h0);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      @(negedge clock);
      chk(status, 8'h04);
      @(posedge clock);
      rd(clkmgr_pkg::CTRL_OFS, 32'h0001_0200);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
